// >>> pkt_buf_device.sv
// Purpose: control registers and buffer pointers of the packet buffer
// Assumes: receive bytes arrive as a valid-qualified stream
// Notes: dma and transmit engines are timers standing in for datapaths
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pkt_buf_device
	import pkt_buf_pkg::*;
(
	input  wire logic                 core_clk,   // clock
	input  wire logic                 rst,        // sync reset
	pkt_buf_if.device                 bus,        // register link
	input  wire logic                 rxValid,    // received byte valid
	input  wire logic [7:0]           rxByte,     // received byte
	input  wire logic                 rxPktEnd,   // last byte, good packet
	input  wire logic                 rxFilterOk, // packet passed filters
	output logic                      txBusy,     // transmit active
	output logic                      rxDropped,  // byte discarded, full
	output logic [1:0]                bankSel,    // register bank
	output logic                      txHeldRst,  // transmit in reset
	output logic                      rxHeldRst,  // receive in reset
	output logic                      sleepMode,  // low power sleep
	output logic                      regLowCur   // regulator low current
);
	import pkt_buf_pkg::*;
	logic [7:0]        mem [MEM_BYTES];
	logic [7:0]        ctrl1, ctrl2, pktCnt, rdata;
	logic [12:0]       rdPtr, wrPtr, rxSt, rxNd, rxRd, rxWr, rxCur, txSt, txNd;
	logic [15:0]       dmaCnt, txCnt;

	function automatic logic [12:0] fifoNext(input logic [12:0] p, input logic [12:0] st,
		input logic [12:0] nd);
		fifoNext = (p == nd) ? st : p + 13'h0001;
	endfunction : fifoNext

	wire wrHit = bus.regWr;
	wire rdHit = bus.regRd;
	wire dataWr = wrHit && bus.regAddr == R_DATA;
	wire dataRd = rdHit && bus.regAddr == R_DATA;
	wire autoAdv = ctrl2[C2_AUTO];
	wire rxOn = ctrl1[C1_RX_ENABLE] && !ctrl1[C1_RX_LOGIC_RESET] && !ctrl2[C2_PSV];
	wire [12:0] rxNext = fifoNext(rxCur, rxSt, rxNd);
	wire rxFull = rxNext == rxRd;
	wire rxStore = rxValid && rxOn && rxFilterOk && !rxFull;
	wire dmaBusy = dmaCnt != 16'h0000;
	wire txActive = txCnt != 16'h0000;
	wire [7:0] c1Read = {ctrl1[7:6], dmaBusy, ctrl1[4], txActive, ctrl1[2:0]};

	assign bankSel = ctrl1[1:0];
	assign txHeldRst = ctrl1[C1_TX_LOGIC_RESET];
	assign rxHeldRst = ctrl1[C1_RX_LOGIC_RESET];
	assign sleepMode = ctrl2[C2_PSV];
	assign regLowCur = ctrl2[C2_PSV] && ctrl2[C2_REGULATOR_LOW_CURRENT];
	assign txBusy = txActive;
	assign bus.regRdata = rdata;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl1 <= CTRL1_RST;
			ctrl2 <= CTRL2_RST;
			pktCnt <= 8'h00;
			rdPtr <= 13'h0000;
			wrPtr <= 13'h0000;
			rxSt <= RXST_RST;
			rxNd <= RXND_RST;
			rxRd <= RXST_RST;
			rxWr <= RXST_RST;
			rxCur <= RXST_RST;
			txSt <= 13'h0000;
			txNd <= 13'h0000;
			dmaCnt <= 16'h0000;
			txCnt <= 16'h0000;
			rxDropped <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			rxDropped <= rxValid && rxOn && rxFilterOk && rxFull;
			if (dmaBusy)
				dmaCnt <= dmaCnt - 16'h0001;
			if (txActive && !ctrl1[C1_TX_LOGIC_RESET])
				txCnt <= txCnt - 16'h0001;
			if (ctrl1[C1_TX_LOGIC_RESET])
				txCnt <= 16'h0000;
			if (rxStore)
			begin
				mem[rxCur] <= rxByte;
				rxCur <= rxNext;
				if (rxPktEnd)
				begin
					rxWr <= rxNext;
					pktCnt <= pktCnt + 8'h01;
				end
			end
			if (ctrl1[C1_RX_LOGIC_RESET])
			begin
				rxCur <= rxSt;
				rxWr <= rxSt;
			end
			if (dataWr)
			begin
				mem[wrPtr] <= bus.regWdata;
				if (autoAdv)
					wrPtr <= wrPtr + 13'h0001;
			end
			if (dataRd && autoAdv)
				rdPtr <= (rdPtr == rxNd) ? rxSt : rdPtr + 13'h0001;
			if (wrHit)
			begin
				case (bus.regAddr)
					R_CTRL1:
					begin
						ctrl1 <= bus.regWdata;
						if (bus.regWdata[C1_DMA] && !dmaBusy)
							dmaCnt <= bus.regWdata[C1_CSUM] ? DMA_CYCLES : DMA_CYCLES + DMA_CYCLES;
						if (bus.regWdata[C1_TXREQ] && !bus.regWdata[C1_TX_LOGIC_RESET])
							txCnt <= TX_CYCLES;
					end
					R_CTRL2:
					begin
						ctrl2 <= bus.regWdata & CTRL2_MASK & ~(8'h01 << C2_PACKET_COUNT_DECREMENT);
						if (bus.regWdata[C2_PACKET_COUNT_DECREMENT] && pktCnt != 8'h00 && !(rxStore && rxPktEnd))
							pktCnt <= pktCnt - 8'h01;
					end
					R_RDPTL: rdPtr[7:0] <= bus.regWdata;
					R_RDPTH: rdPtr[12:8] <= bus.regWdata[4:0];
					R_WRPTL: wrPtr[7:0] <= bus.regWdata;
					R_WRPTH: wrPtr[12:8] <= bus.regWdata[4:0];
					R_RXSTL: rxSt[7:0] <= bus.regWdata;
					R_RXSTH: rxSt[12:8] <= bus.regWdata[4:0];
					R_RXNDL: rxNd[7:0] <= bus.regWdata;
					R_RXNDH: rxNd[12:8] <= bus.regWdata[4:0];
					R_RXRDL: rxRd[7:0] <= bus.regWdata;
					R_RXRDH: rxRd[12:8] <= bus.regWdata[4:0];
					R_TXSTL: txSt[7:0] <= bus.regWdata;
					R_TXSTH: txSt[12:8] <= bus.regWdata[4:0];
					R_TXNDL: txNd[7:0] <= bus.regWdata;
					R_TXNDH: txNd[12:8] <= bus.regWdata[4:0];
					default: ;
				endcase
			end
			if (rdHit)
			begin
				case (bus.regAddr)
					R_CTRL1: rdata <= c1Read;
					R_CTRL2: rdata <= ctrl2;
					R_RDPTL: rdata <= rdPtr[7:0];
					R_RDPTH: rdata <= {3'h0, rdPtr[12:8]};
					R_WRPTL: rdata <= wrPtr[7:0];
					R_WRPTH: rdata <= {3'h0, wrPtr[12:8]};
					R_RXSTL: rdata <= rxSt[7:0];
					R_RXSTH: rdata <= {3'h0, rxSt[12:8]};
					R_RXNDL: rdata <= rxNd[7:0];
					R_RXNDH: rdata <= {3'h0, rxNd[12:8]};
					R_RXRDL: rdata <= rxRd[7:0];
					R_RXRDH: rdata <= {3'h0, rxRd[12:8]};
					R_RXWRL: rdata <= rxWr[7:0];
					R_RXWRH: rdata <= {3'h0, rxWr[12:8]};
					R_TXSTL: rdata <= txSt[7:0];
					R_TXSTH: rdata <= {3'h0, txSt[12:8]};
					R_TXNDL: rdata <= txNd[7:0];
					R_TXNDH: rdata <= {3'h0, txNd[12:8]};
					R_PKTCNT: rdata <= pktCnt;
					R_DATA: rdata <= mem[rdPtr];
					R_STAT: rdata <= {7'h00, rxDropped};
					default: rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : pkt_buf_device
`default_nettype wire

// >>> pkt_buf_host.sv
// Purpose: host-side controller issuing register accesses to the device
// Assumes: user issues one access per cycle, never while rdValid pending
// Notes: bounds writes are refused and dropped while receive is enabled
`timescale 1ns/1ps
`default_nettype none
module pkt_buf_host
	import pkt_buf_pkg::*;
(
	input  wire logic                 core_clk,  // clock
	input  wire logic                 rst,       // sync reset
	pkt_buf_if.host                   bus,       // register link
	input  wire logic                 userWr,    // write request
	input  wire logic                 userRd,    // read request
	input  wire logic [4:0]           userAddr,  // register index
	input  wire logic [7:0]           userWdata, // write data
	output logic [7:0]                userRdata, // read data
	output logic                      rdValid,   // read data valid pulse
	output logic                      refused    // bounds write refused pulse
);
	import pkt_buf_pkg::*;
	logic rxEnShadow, rdPend;

	// bounds must not move under an active receiver
	wire isBound = userAddr >= R_RXSTL && userAddr <= R_RXNDH;
	wire block = userWr && isBound && rxEnShadow;
	wire doWr = userWr && !block;

	assign bus.regAddr = userAddr;
	assign bus.regWdata = userWdata;
	assign bus.regWr = doWr;
	assign bus.regRd = userRd && !userWr;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rxEnShadow <= 1'b0;
			rdPend <= 1'b0;
			rdValid <= 1'b0;
			refused <= 1'b0;
			userRdata <= 8'h00;
		end
		else
		begin
			rdPend <= bus.regRd;
			rdValid <= rdPend;
			refused <= block;
			if (rdPend)
				userRdata <= bus.regRdata;
			if (doWr && userAddr == R_CTRL1)
				rxEnShadow <= userWdata[C1_RX_ENABLE];
		end
	end
endmodule : pkt_buf_host
`default_nettype wire

// >>> pkt_buf_if.sv
// Purpose: link between host-side controller and packet buffer device
// Assumes: one clock, device answers reads one cycle later
// Notes: byte-wide register port only; the receive byte stream is not on the link
`timescale 1ns/1ps
`default_nettype none
interface pkt_buf_if (input wire logic core_clk);
	logic [4:0] regAddr;
	logic [7:0] regWdata;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdata;
	modport device (input regAddr, input regWdata, input regWr, input regRd, output regRdata);
	modport host (output regAddr, output regWdata, output regWr, output regRd, input regRdata);
endinterface : pkt_buf_if
`default_nettype wire

// >>> pkt_buf_pkg.sv
// Purpose: shared constants for the packet buffer control block
// Assumes: 8-Kbyte buffer, byte-wide register file behind a plain port
// Notes: register indices on the link are the designer's own map
// Summary of operation
// - tx_logic_reset high holds transmit logic reset
// - rx_logic_reset high holds receive logic reset
// - dma_go_busy starts dma, reads busy
// - checksum select picks checksum over copy
// - tx_request reads one while transmitting
// - rx_enable gates storing of received bytes
// - bank_select chooses one of four banks
// - auto advance moves pointers after data access
// - packet decrement lowers count once, self-clears; dropped if a good packet ends in the same cycle
// - power_save puts logic into sleep
// - regulator low current only under power save
// - 8 Kbyte memory split by host pointers
// - fifo includes both start and end bytes
// - receive writes wrap from end to start
// - host changes fifo bounds only while disabled
// - fifo may wrap across top of memory
// - write pointer read-only, updated per packet
// - never write at the read pointer location (here a byte is stored at rxRd; only the slot before rxRd is never written)
// - full fifo discards new data
// - host advances read pointer after processing
// - host keeps tx area off receive fifo
// - host reads wrap in fifo, writes never
package pkt_buf_pkg;
	localparam int ADDR_W = 13;
	localparam int MEM_BYTES = 8192;
	localparam int RIDX_W = 5;
	localparam logic [4:0] R_CTRL1 = 5'h00;
	localparam logic [4:0] R_CTRL2 = 5'h01;
	localparam logic [4:0] R_RDPTL = 5'h02;
	localparam logic [4:0] R_RDPTH = 5'h03;
	localparam logic [4:0] R_WRPTL = 5'h04;
	localparam logic [4:0] R_WRPTH = 5'h05;
	localparam logic [4:0] R_RXSTL = 5'h06;
	localparam logic [4:0] R_RXSTH = 5'h07;
	localparam logic [4:0] R_RXNDL = 5'h08;
	localparam logic [4:0] R_RXNDH = 5'h09;
	localparam logic [4:0] R_RXRDL = 5'h0A;
	localparam logic [4:0] R_RXRDH = 5'h0B;
	localparam logic [4:0] R_RXWRL = 5'h0C;
	localparam logic [4:0] R_RXWRH = 5'h0D;
	localparam logic [4:0] R_TXSTL = 5'h0E;
	localparam logic [4:0] R_TXSTH = 5'h0F;
	localparam logic [4:0] R_TXNDL = 5'h10;
	localparam logic [4:0] R_TXNDH = 5'h11;
	localparam logic [4:0] R_PKTCNT = 5'h12;
	localparam logic [4:0] R_DATA = 5'h13;
	localparam logic [4:0] R_STAT = 5'h14;
	localparam int C1_TX_LOGIC_RESET = 7;
	localparam int C1_RX_LOGIC_RESET = 6;
	localparam int C1_DMA = 5;
	localparam int C1_CSUM = 4;
	localparam int C1_TXREQ = 3;
	localparam int C1_RX_ENABLE = 2;
	localparam int C2_AUTO = 7;
	localparam int C2_PACKET_COUNT_DECREMENT = 6;
	localparam int C2_PSV = 5;
	localparam int C2_REGULATOR_LOW_CURRENT = 3;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h80;
	localparam logic [7:0] CTRL2_MASK = 8'hE8;
	localparam logic [12:0] RXST_RST = 13'h05FA;
	localparam logic [12:0] RXND_RST = 13'h1FFF;
	localparam logic [15:0] DMA_CYCLES = 16'h0010;
	localparam logic [15:0] TX_CYCLES = 16'h0040;
endpackage : pkt_buf_pkg

// >>> pkt_buf_props.sv
// Purpose: link checks
// Assumes: one clock
// Notes: watches the shared link
`timescale 1ns/1ps
`default_nettype none
module pkt_buf_props
	import pkt_buf_pkg::*;
(
	input wire logic       core_clk, // clock
	input wire logic       rst,      // reset
	input wire logic [4:0] regAddr,  // index
	input wire logic [7:0] regWdata, // data
	input wire logic       regWr,    // write
	input wire logic       regRd,    // read
	input wire logic [7:0] regRdata  // answer
);
	logic rxOn;
	wire c1w = regWr && regAddr == R_CTRL1;
	wire c2w = regWr && regAddr == R_CTRL2;
	wire c1r = regRd && regAddr == R_CTRL1;
	wire c2r = regRd && regAddr == R_CTRL2;
	always_ff @(posedge core_clk)
		if (rst) rxOn <= 1'b0;
		else if (c1w) rxOn <= regWdata[C1_RX_ENABLE];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_bounds_held: assert property (
		regWr && rxOn |-> !(regAddr inside {[R_RXSTL:R_RXNDH]})) else $error("bounds");
	a_ctrl1_back: assert property (c1w ##2 c1r |=>
		regRdata[7:6] == $past(regWdata[7:6], 3) && regRdata[2:0] == $past(regWdata[2:0], 3))
		else $error("ctrl1");
	a_ctrl2_back: assert property (c2w ##2 c2r |=>
		(regRdata & CTRL2_MASK & 8'hBF) == ($past(regWdata, 3) & CTRL2_MASK & 8'hBF))
		else $error("ctrl2");
	a_ctrl2_clear: assert property (c2r && !$past(c2w) |=>
		(regRdata & 8'h57) == 8'h00) else $error("ctrl2 zeros");
	a_tx_busy: assert property (
		c1w && regWdata[3] && !regWdata[7] ##2 c1r |=> regRdata[3]) else $error("tx");
	a_dma_busy: assert property (
		c1w && regWdata[5] ##2 c1r |=> regRdata[5]) else $error("dma");
	a_unmapped_zero: assert property (
		regRd && regAddr > R_STAT |=> regRdata == 8'h00) else $error("unmapped");
	a_rdata_hold: assert property (!regRd |=> $stable(regRdata)) else $error("hold");
	cover property (c1w ##2 c1r);
	cover property (regRd && regAddr == R_DATA);
	cover property (c2w && regWdata[C2_PACKET_COUNT_DECREMENT]);
endmodule : pkt_buf_props
`default_nettype wire

// >>> tb_packet_buffer_control.sv
// Purpose: bench for both ends
// Assumes: host passes one access per cycle
// Notes: tiny receive window forces wrap and full
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb_packet_buffer_control;
	import pkt_buf_pkg::*;
	logic       core_clk, rst, userWr, userRd, rdValid, refused, rxValid, rxPktEnd, seen, hit;
	logic       txBusy, rxDropped, txHeldRst, rxHeldRst, sleepMode, regLowCur;
	logic [1:0] bankSel;
	logic [4:0] userAddr;
	logic [7:0] userWdata, userRdata, rxByte;
	int         num_errors = 0;
	int         checked = 0;
	pkt_buf_if link (.core_clk(core_clk));
	pkt_buf_host pkt_buf_host_i (.core_clk(core_clk), .rst(rst), .bus(link), .userWr(userWr),
		.userRd(userRd), .userAddr(userAddr), .userWdata(userWdata),
		.userRdata(userRdata), .rdValid(rdValid), .refused(refused));
	pkt_buf_device pkt_buf_device_i (.core_clk(core_clk), .rst(rst), .bus(link),
		.rxValid(rxValid), .rxByte(rxByte), .rxPktEnd(rxPktEnd), .rxFilterOk(1'b1),
		.txBusy(txBusy), .rxDropped(rxDropped), .bankSel(bankSel), .txHeldRst(txHeldRst),
		.rxHeldRst(rxHeldRst), .sleepMode(sleepMode), .regLowCur(regLowCur));
	pkt_buf_props pkt_buf_props_i (.core_clk(core_clk), .rst(rst),
		.regAddr(link.regAddr), .regWdata(link.regWdata), .regWr(link.regWr),
		.regRd(link.regRd), .regRdata(link.regRdata));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// pulses are caught mid-cycle so no edge race can hide them
	always @(negedge core_clk)
		if (refused || rxDropped)
			hit = 1'b1;
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle
	// one spare cycle so back-to-back calls never rewrite the strobe in one step
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		userAddr <= a;
		userWdata <= d;
		userWr <= 1'b1;
		@(posedge core_clk);
		userWr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic wp(input logic [4:0] a, input logic [12:0] v);
		wr(a, v[7:0]);
		wr(a + 5'h01, {3'h0, v[12:8]});
	endtask : wp
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		userAddr <= a;
		userRd <= 1'b1;
		@(posedge core_clk);
		userRd <= 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 4 && seen !== 1'b1; i++)
		begin
			@(negedge core_clk);
			seen = rdValid;
		end
		`CHK(userRdata, e)
		@(posedge core_clk);
	endtask : rd
	// bytes count up from b; last one closes a good packet
	task automatic pkt(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxValid <= 1'b1;
			rxByte <= b + 8'(i);
			rxPktEnd <= (i == n - 1);
			idle(1);
		end
		rxValid <= 1'b0;
		rxPktEnd <= 1'b0;
		idle(3);
	endtask : pkt
	task automatic finish_test();
		$display("checked %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial
	begin
		rst = 1'b1;
		{userWr, userRd, rxValid, rxPktEnd, seen, hit} = '0;
		{userAddr, userWdata, rxByte} = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(R_CTRL2, CTRL2_RST);
		rd(R_RXSTH, 8'h05);
		rd(5'h1F, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(R_CTRL1, 8'hC0 | 8'(i));
			rd(R_CTRL1, 8'hC0 | 8'(i));
			`CHK(bankSel, 2'(i))
		end
		`CHK({txHeldRst, rxHeldRst}, 2'b11)
		wr(R_CTRL2, 8'h28);
		rd(R_CTRL2, 8'h28);
		`CHK({sleepMode, regLowCur}, 2'b11)
		wr(R_CTRL2, 8'h08);
		idle(3);
		`CHK({sleepMode, regLowCur}, 2'b00)
		wr(R_CTRL2, 8'h80);
		$display("control test done");
		wr(R_CTRL1, 8'h08);
		rd(R_CTRL1, 8'h08);
		`CHK(txBusy, 1'b1)
		idle(70);
		rd(R_CTRL1, 8'h00);
		wr(R_CTRL1, 8'h30);
		rd(R_CTRL1, 8'h30);
		idle(20);
		rd(R_CTRL1, 8'h10);
		wr(R_CTRL1, 8'h20);
		idle(16);
		rd(R_CTRL1, 8'h20);
		idle(20);
		rd(R_CTRL1, 8'h00);
		$display("busy test done");
		// four-byte window so wrap and full show up within a few packets
		wp(R_RXSTL, 13'h0010);
		wp(R_RXNDL, 13'h0013);
		wp(R_RXRDL, 13'h0010);
		wp(R_RDPTL, 13'h0010);
		wr(R_CTRL1, 8'h40);
		idle(3);
		`CHK(rxHeldRst, 1'b1)
		wr(R_CTRL1, 8'h04);
		pkt(8'hA0, 3);
		rd(R_RXWRL, 8'h13);
		rd(R_DATA, 8'hA0);
		rd(R_DATA, 8'hA1);
		rd(R_DATA, 8'hA2);
		wp(R_RXRDL, 13'h0013);
		pkt(8'hB0, 2);
		rd(R_RXWRL, 8'h11);
		wr(R_CTRL2, 8'hC0);
		rd(R_PKTCNT, 8'h01);
		rd(R_CTRL2, 8'h80);
		hit = 1'b0;
		pkt(8'hC0, 3);
		`CHK(hit, 1'b1)
		hit = 1'b0;
		wr(R_RXSTL, 8'h00);
		idle(3);
		`CHK(hit, 1'b1)
		wp(R_RDPTL, 13'h0013);
		rd(R_DATA, 8'hB0);
		rd(R_DATA, 8'hB1);
		wr(R_CTRL2, 8'h00);
		wp(R_RDPTL, 13'h0013);
		rd(R_DATA, 8'hB0);
		rd(R_DATA, 8'hB0);
		$display("receive test done");
		finish_test();
	end
	initial
	begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		finish_test();
	end
endmodule : tb_packet_buffer_control
`default_nettype wire
